// ===== sar_adc_readout.sv
// sar_adc_readout.sv: conversion control, sleep/hold control and 3-wire serial readout of a 12-bit converter
// assumes: CLK stands in for the internal oscillator; SCK and CONVERT_STROBE come from the host,
// AIN_CODE is the digitised input seen by the sample-and-hold; no software registers
`timescale 1ns/1ns
`default_nettype none
`include "sar_consts.svh"

module sar_adc_readout
    import sar_pkg::*;
#(
    parameter int CONVERSION_INTERVAL_NS = `SAR_CONVERSION_INTERVAL_NS,
    parameter int ACQUIRE_INTERVAL_NS  = `SAR_ACQUIRE_INTERVAL_NS
) (
    input  wire logic                     CLK,            // internal conversion clock, 100 MHz
    input  wire logic                     RST_N,          // asynchronous reset, low active
    input  wire logic                     SCK,            // shift clock from the host
    input  wire logic                     CONVERT_STROBE, // convert strobe pin from the host
    input  wire logic [`SAR_RES_BITS-1:0] AIN_CODE,       // digitised analog input
    output logic                          SERIAL_RESULT_OUT,    // serial data, output side of the pin
    output logic                          SERIAL_RESULT_OUT_OE, // high while the pin is driven
    output logic                          SLEEP_O,        // low-power sleep state
    output logic                          HOLD_O,         // sample-and-hold in hold
    output logic                          BUSY_O,         // conversion in progress
    output logic                          ACQ_DONE_O,     // input fully acquired
    output logic                          OVERRUN_O       // a result was dropped, buffer full
);
    // conversion time rounds up but each bit step rounds down, so conversion can run short; acquire time rounds up and is a least time
    localparam int CONVERT_STROBE_CYC = (CONVERSION_INTERVAL_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS;
    localparam int STEP_CYC = (CONVERT_STROBE_CYC / `SAR_RES_BITS) < 1 ? 1 : (CONVERT_STROBE_CYC / `SAR_RES_BITS);
    localparam int ACQ_CYC  = ((ACQUIRE_INTERVAL_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS) < 1 ? 1
                              : ((ACQUIRE_INTERVAL_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS);
    localparam logic [`SAR_CNT_W-1:0] STEP_LAST = `SAR_CNT_W'(STEP_CYC - 1);
    localparam logic [`SAR_CNT_W-1:0] ACQ_LAST  = `SAR_CNT_W'(ACQ_CYC - 1);

    sar_core_s   c_ff;
    sar_core_s   nxt_c;
    sar_link_s   l_ff;
    sar_link_s   nxt_l;
    sar_status_s status;

    logic        convert_strobe_rise;
    logic        convert_strobe_fall;
    sar_word_t   trial;
    logic        buf_in_valid;
    logic        buf_in_ready;
    logic        buf_out_valid;
    logic        buf_out_ready;
    sar_word_t   buf_out_data;
    logic        link_rst_n;
    logic [`SAR_IDX_W-1:0] sel_idx;
    sar_word_t   test_mask;
    sar_word_t   pin_mask;
    logic        frame_bit;

    assign convert_strobe_rise = c_ff.convert_strobe_lvl & ~c_ff.convert_strobe_prev;
    assign convert_strobe_fall = ~c_ff.convert_strobe_lvl & c_ff.convert_strobe_prev;

    // one-hot decodes: the bit under test, and the bit the pin shows
    for (genvar b = 0; b < `SAR_RES_BITS; b++) begin : g_bit
        assign test_mask[b] = (c_ff.bit_idx == `SAR_IDX_W'(b));
        assign pin_mask[b]  = (sel_idx == `SAR_IDX_W'(b));
    end

    // trial word sets the bit under test on top of the bits already decided
    assign trial = c_ff.approx | test_mask;

    // two-entry buffer between the approximation engine and the readout store
    assign buf_in_valid  = (c_ff.state == SAR_ST_STORE);
    assign buf_out_ready = convert_strobe_fall;

    sar_fifo #(
        .W (`SAR_RES_BITS),
        .D (`SAR_BUF_DEPTH)
    ) u_buf (
        .clk       (CLK),
        .rst_n     (RST_N),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (c_ff.approx),
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (buf_out_data)
    );

    always_comb begin
        nxt_c = c_ff;
        nxt_c.convert_strobe_meta = CONVERT_STROBE;
        nxt_c.convert_strobe_lvl  = c_ff.convert_strobe_meta;
        nxt_c.convert_strobe_prev = c_ff.convert_strobe_lvl;
        nxt_c.ain_meta  = AIN_CODE;
        nxt_c.ain_lvl   = c_ff.ain_meta;

        // acquisition timing restarts whenever the strobe falls
        if (convert_strobe_fall) begin
            nxt_c.acq_cnt  = `SAR_CNT_ZERO;
            nxt_c.acq_done = 1'b0;
        end else if (c_ff.state == SAR_ST_TRACK && !c_ff.acq_done) begin
            if (c_ff.acq_cnt == ACQ_LAST) begin
                nxt_c.acq_done = 1'b1;
            end else begin
                nxt_c.acq_cnt = `SAR_CNT_W'(c_ff.acq_cnt + 1'b1);
            end
        end

        // readout store takes the next result as the strobe falls
        if (convert_strobe_fall && buf_out_valid) begin
            nxt_c.word    = buf_out_data;
            nxt_c.word_ok = 1'b1;
        end

        case (c_ff.state)
            SAR_ST_TRACK: begin
                if (convert_strobe_rise) begin
                    nxt_c.state    = SAR_ST_CONVERT;
                    nxt_c.held     = c_ff.ain_lvl;
                    nxt_c.approx   = `SAR_ZERO_WORD;
                    nxt_c.bit_idx  = `SAR_MSB_IDX;
                    nxt_c.step_cnt = `SAR_CNT_ZERO;
                end
            end
            SAR_ST_CONVERT: begin
                if (convert_strobe_fall) begin
                    // strobe dropped too early: conversion abandoned
                    nxt_c.state = SAR_ST_TRACK;
                end else if (c_ff.step_cnt == STEP_LAST) begin
                    nxt_c.step_cnt = `SAR_CNT_ZERO;
                    if (trial <= c_ff.held) begin
                        nxt_c.approx = trial;
                    end
                    if (c_ff.bit_idx == `SAR_IDX_ZERO) begin
                        nxt_c.state = SAR_ST_STORE;
                    end else begin
                        nxt_c.bit_idx = `SAR_IDX_W'(c_ff.bit_idx - 1'b1);
                    end
                end else begin
                    nxt_c.step_cnt = `SAR_CNT_W'(c_ff.step_cnt + 1'b1);
                end
            end
            SAR_ST_STORE: begin
                if (buf_in_ready) begin
                    nxt_c.state = c_ff.convert_strobe_lvl ? SAR_ST_SLEEP : SAR_ST_TRACK;
                end else if (convert_strobe_fall) begin
                    nxt_c.overrun = 1'b1;
                    nxt_c.state   = SAR_ST_TRACK;
                end
            end
            SAR_ST_SLEEP: begin
                if (convert_strobe_fall) begin
                    nxt_c.state = SAR_ST_TRACK;
                end
            end
            default: begin
                nxt_c.state = SAR_ST_TRACK;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            c_ff <= '0;
        end else begin
            c_ff <= nxt_c;
        end
    end

    // shift side: counter cleared for as long as the strobe is high, so each frame starts at the MSB
    assign link_rst_n = RST_N & ~c_ff.convert_strobe_lvl;

    always_comb begin
        nxt_l = l_ff;
        if (l_ff.bit_cnt != `SAR_RDIDX_W'(`SAR_RES_BITS)) begin
            nxt_l.bit_cnt = `SAR_RDIDX_W'(l_ff.bit_cnt + 1'b1);
        end
    end

    always_ff @(negedge SCK or negedge link_rst_n) begin
        if (!link_rst_n) begin
            l_ff <= '0;
        end else begin
            l_ff <= nxt_l;
        end
    end

    // the store is steady while the strobe is low, so the shift side may read it directly
    assign sel_idx = `SAR_IDX_W'(`SAR_MSB_IDX - l_ff.bit_cnt[`SAR_IDX_W-1:0]);

    // past the last result bit, or with no result yet, the pin shows zeros
    assign frame_bit = (l_ff.bit_cnt < `SAR_RDIDX_W'(`SAR_RES_BITS)) && c_ff.word_ok;

    always_comb begin
        SERIAL_RESULT_OUT = frame_bit & (|(c_ff.word & pin_mask));
    end

    // driven only while the strobe is low; the host samples on rising SCK
    assign SERIAL_RESULT_OUT_OE = ~c_ff.convert_strobe_lvl;

    always_comb begin
        status.sleeping   = (c_ff.state == SAR_ST_SLEEP);
        status.holding    = (c_ff.state != SAR_ST_TRACK);
        status.converting = (c_ff.state == SAR_ST_CONVERT) || (c_ff.state == SAR_ST_STORE);
        status.acquired   = (c_ff.state == SAR_ST_TRACK) && c_ff.acq_done;
        status.overrun    = c_ff.overrun;
    end

    assign SLEEP_O    = status.sleeping;
    assign HOLD_O     = status.holding;
    assign BUSY_O     = status.converting;
    assign ACQ_DONE_O = status.acquired;
    assign OVERRUN_O  = status.overrun;

endmodule // sar_adc_readout

`default_nettype wire

// ===== sar_consts.svh
// sar_consts.svh: timing figures, widths and reset values of the sampling converter control block
// assumes: included by bare name from the package and the design modules
`ifndef SAR_CONSTS_SVH
`define SAR_CONSTS_SVH

`define SAR_CLK_NS        10
`define SAR_CONVERSION_INTERVAL_NS      1500
`define SAR_ACQUIRE_INTERVAL_NS       500
`define SAR_RES_BITS      12
`define SAR_CNT_W         8
`define SAR_IDX_W         4
`define SAR_RDIDX_W       5
`define SAR_BUF_DEPTH     2
`define SAR_ZERO_WORD     12'h000
`define SAR_CNT_ZERO      8'h00
`define SAR_IDX_ZERO      4'h0
`define SAR_RDIDX_ZERO    5'h00
`define SAR_MSB_IDX       4'hB

`endif

// ===== sar_pkg.sv
// sar_pkg.sv: types shared by the converter control block
// assumes: sar_consts.svh is on the include path
`include "sar_consts.svh"

package sar_pkg;

    typedef enum logic [1:0] {
        SAR_ST_TRACK,
        SAR_ST_CONVERT,
        SAR_ST_STORE,
        SAR_ST_SLEEP
    } sar_state_e;

    typedef logic [`SAR_RES_BITS-1:0] sar_word_t;

    // state of the converter side, clocked by the system clock
    typedef struct packed {
        sar_state_e             state;
        logic                   convert_strobe_meta;
        logic                   convert_strobe_lvl;
        logic                   convert_strobe_prev;
        sar_word_t              ain_meta;
        sar_word_t              ain_lvl;
        sar_word_t              held;
        sar_word_t              approx;
        logic [`SAR_IDX_W-1:0]  bit_idx;
        logic [`SAR_CNT_W-1:0]  step_cnt;
        logic [`SAR_CNT_W-1:0]  acq_cnt;
        logic                   acq_done;
        sar_word_t              word;
        logic                   word_ok;
        logic                   overrun;
    } sar_core_s;

    // state of the shift side, clocked by the falling shift clock
    typedef struct packed {
        logic [`SAR_RDIDX_W-1:0] bit_cnt;
    } sar_link_s;

    // status pins gathered together
    typedef struct packed {
        logic sleeping;
        logic holding;
        logic converting;
        logic acquired;
        logic overrun;
    } sar_status_s;

endpackage : sar_pkg

// ===== sar_fifo.sv
// sar_fifo.sv: small valid/ready buffer, storage in flip-flops addressed by index
// assumes: both sides on one clock; reset asynchronous, active low
`timescale 1ns/1ns
`default_nettype none

module sar_fifo #(
    parameter int W = 12,
    parameter int D = 2
) (
    input  wire logic         clk,       // clock
    input  wire logic         rst_n,     // asynchronous reset, low active
    input  wire logic         in_valid,  // writer offers a word
    output logic              in_ready,  // room for a word
    input  wire logic [W-1:0] in_data,   // word offered
    output logic              out_valid, // a word is waiting
    input  wire logic         out_ready, // reader takes the word
    output logic [W-1:0]      out_data   // oldest word
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } sar_fifo_s;

    sar_fifo_s q_ff;
    sar_fifo_s nxt_q;
    logic      push;
    logic      pop;

    assign in_ready  = (q_ff.cnt != (AW+1)'(D));
    assign out_valid = (q_ff.cnt != '0);
    assign out_data  = q_ff.mem[q_ff.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        nxt_q = q_ff;
        if (push) begin
            nxt_q.mem[q_ff.wp] = in_data;
            nxt_q.wp = (q_ff.wp == AW'(D-1)) ? '0 : AW'(q_ff.wp + 1'b1);
        end
        if (pop) begin
            nxt_q.rp = (q_ff.rp == AW'(D-1)) ? '0 : AW'(q_ff.rp + 1'b1);
        end
        if (push && !pop) begin
            nxt_q.cnt = (AW+1)'(q_ff.cnt + 1'b1);
        end else if (pop && !push) begin
            nxt_q.cnt = (AW+1)'(q_ff.cnt - 1'b1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

endmodule // sar_fifo

`default_nettype wire

// ===== sar_adc_readout_end.sv
// sar_adc_readout_end.sv: holds no logic; the block lives in sar_adc_readout.sv
// assumes: nothing of its surroundings
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ===== sar_readout_checker.sv
// sar_readout_checker.sv: timing checks on the converter control ports
// assumes: bound into sar_adc_readout, all checks on CLK
`timescale 1ns/1ns
`default_nettype none
module sar_readout_checker #(
    parameter int CONVERSION_INTERVAL_NS = 1500,
    parameter int ACQUIRE_INTERVAL_NS  = 500
) (
    input wire logic CLK,                  // clock
    input wire logic RST_N,                // reset, low active
    input wire logic CONVERT_STROBE,       // strobe pin
    input wire logic SERIAL_RESULT_OUT_OE, // data pin driven
    input wire logic SLEEP_O,              // sleeping
    input wire logic HOLD_O,               // holding
    input wire logic BUSY_O,               // converting
    input wire logic ACQ_DONE_O            // acquired
);
    localparam int CONVERT_STROBE_CYC = (CONVERSION_INTERVAL_NS / 120) * 12 + 1;
    localparam int ACQ_CYC  = ACQUIRE_INTERVAL_NS / 10;
    logic [7:0] busy_cnt_ff;
    logic [7:0] nxt_busy_cnt;
    logic [7:0] trk_cnt_ff;
    logic [7:0] nxt_trk_cnt;
    always_comb begin
        nxt_busy_cnt = BUSY_O ? busy_cnt_ff + 8'h01 : 8'h00;
        nxt_trk_cnt  = (HOLD_O || trk_cnt_ff == 8'hFF) ? (HOLD_O ? 8'h00 : 8'hFF) : trk_cnt_ff + 8'h01;
    end
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            busy_cnt_ff <= 8'h00;
            trk_cnt_ff  <= 8'h00;
        end else begin
            busy_cnt_ff <= nxt_busy_cnt;
            trk_cnt_ff  <= nxt_trk_cnt;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_strobe_up;
        $rose(CONVERT_STROBE) && !HOLD_O;
    endsequence
    sequence s_woken;
        ##[1:5] (SERIAL_RESULT_OUT_OE && !SLEEP_O && !HOLD_O);
    endsequence
    a_rise_floats_out: assert property (s_strobe_up |-> ##[1:4] !SERIAL_RESULT_OUT_OE)
        else $error("output driven after strobe rise");
    a_rise_starts_convert_strobe: assert property (s_strobe_up |-> ##[2:5] BUSY_O)
        else $error("no conversion after strobe rise");
    a_high_keeps_float: assert property (CONVERT_STROBE [*5] |-> !SERIAL_RESULT_OUT_OE)
        else $error("output driven while strobe high");
    a_low_keeps_drive: assert property ((!CONVERT_STROBE) [*5] |-> SERIAL_RESULT_OUT_OE)
        else $error("output floating while strobe low");
    a_fall_wakes_up: assert property ($fell(CONVERT_STROBE) |-> s_woken)
        else $error("no wake after strobe fall");
    a_convert_strobe_length: assert property ($fell(BUSY_O) && SLEEP_O |-> busy_cnt_ff == CONVERT_STROBE_CYC)
        else $error("conversion length wrong");
    a_sleep_after_convert_strobe: assert property ($fell(BUSY_O) && CONVERT_STROBE |-> SLEEP_O)
        else $error("no sleep after conversion");
    a_sleep_holds: assert property (SLEEP_O |-> HOLD_O && !BUSY_O)
        else $error("sample released in sleep");
    a_acq_time: assert property ($rose(ACQ_DONE_O) |-> trk_cnt_ff inside {[ACQ_CYC-3:ACQ_CYC+3]})
        else $error("acquire interval wrong");
endmodule // sar_readout_checker
bind sar_adc_readout sar_readout_checker #(.CONVERSION_INTERVAL_NS(CONVERSION_INTERVAL_NS), .ACQUIRE_INTERVAL_NS(ACQUIRE_INTERVAL_NS)) sar_readout_checker_i (
    .CLK(CLK), .RST_N(RST_N), .CONVERT_STROBE(CONVERT_STROBE), .SERIAL_RESULT_OUT_OE(SERIAL_RESULT_OUT_OE),
    .SLEEP_O(SLEEP_O), .HOLD_O(HOLD_O), .BUSY_O(BUSY_O), .ACQ_DONE_O(ACQ_DONE_O)
);
`default_nettype wire

// ===== sar_host_model.sv
// sar_host_model.sv: serial host driving strobe and shift clock
// assumes: tasks called by the bench; data line resolved outside
`timescale 1ns/1ns
`default_nettype none
module sar_host_model (
    input  wire logic clk,           // paces the strobe
    input  wire logic sdo_pin,       // resolved data line
    output var logic  sck,           // shift clock, still outside frames
    output var logic  convert_strobe // convert strobe
);
    initial begin
        sck = 1'b0;
        convert_strobe = 1'b0;
    end
    // after a fall, leave setup time before the first shift edge
    task automatic strobe(input logic lvl);
        @(negedge clk);
        convert_strobe = lvl;
        if (!lvl) #40;
    endtask
    // 12 ns shift clock, idle low so nothing moves during conversion
    task automatic read_bits(input int n, output logic [15:0] got);
        got = 16'h0000;
        for (int i = 0; i < n; i++) begin
            #6 sck = 1'b1;
            got = {got[14:0], sdo_pin};
            #6 sck = 1'b0;
        end
    endtask
endmodule // sar_host_model
`default_nettype wire

// ===== test_sar_adc_serial_readout.sv
// test_sar_adc_serial_readout.sv: self-checking bench of the converter control block
// assumes: package, design, host model and checker compiled first
`timescale 1ns/1ns
`default_nettype none
module test_sar_adc_serial_readout;
    import sar_pkg::*;
    logic        clk;
    logic        rst_n;
    sar_word_t   ain_code;
    logic        sck, strobe, serial_result_out, sdo_oe, sleep, hold, busy, acq, ovr;
    wire         sdo_pin;
    logic [15:0] got;
    int          miscompares;
    int          n_tests;
    // a floating pin reads the inverse of the driven value
    assign sdo_pin = sdo_oe ? serial_result_out : ~serial_result_out;
    sar_adc_readout sar_adc_readout_i (
        .CLK(clk), .RST_N(rst_n), .SCK(sck), .CONVERT_STROBE(strobe), .AIN_CODE(ain_code),
        .SERIAL_RESULT_OUT(serial_result_out), .SERIAL_RESULT_OUT_OE(sdo_oe), .SLEEP_O(sleep), .HOLD_O(hold),
        .BUSY_O(busy), .ACQ_DONE_O(acq), .OVERRUN_O(ovr)
    );
    sar_host_model sar_host_model_i (.clk(clk), .sdo_pin(sdo_pin), .sck(sck), .convert_strobe(strobe));
    always #5 clk = ~clk;
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wait_hi(input logic sel, input string nm);
        int k;
        k = 0;
        while (((sel ? acq : sleep) !== 1'b1) && k < 400) begin
            @(negedge clk);
            k++;
        end
        if ((sel ? acq : sleep) !== 1'b1) begin
            miscompares++;
            $display("[FAIL] %s expected 1 seen timeout", nm);
            final_report();
        end
    endtask
    task automatic t_reset();
        rst_n = 1'b0;
        repeat (16) @(negedge clk);
        chk_bit("oe_rst", 1'b1, sdo_oe);
        chk_bit("out_rst", 1'b0, serial_result_out);
        chk_word("flags_rst", 16'h0000, {11'h000, sleep, hold, busy, acq, ovr});
        rst_n = 1'b1;
        wait_hi(1'b1, "acq_rst");
        $display("done reset");
    endtask
    task automatic t_convert(input sar_word_t code);
        @(negedge clk);
        ain_code = code;
        sar_host_model_i.strobe(1'b1);
        repeat (4) @(negedge clk);
        chk_bit("busy", 1'b1, busy);
        chk_bit("oe_convert_strobe", 1'b0, sdo_oe);
        wait_hi(1'b0, "sleep");
        chk_bit("hold", 1'b1, hold);
        ain_code = ~code;
        repeat (20) @(negedge clk);
        sar_host_model_i.strobe(1'b0);
        chk_bit("oe_read", 1'b1, sdo_oe);
        chk_bit("wake", 1'b0, hold | sleep);
        sar_host_model_i.read_bits(16, got);
        chk_word("frame", {code, 4'h0}, got);
        sar_host_model_i.read_bits(4, got);
        chk_word("tail", 16'h0000, got);
        wait_hi(1'b1, "acq");
        $display("done convert %h", code);
    endtask
    task automatic t_abort(input sar_word_t prev);
        sar_host_model_i.strobe(1'b1);
        repeat (50) @(negedge clk);
        chk_bit("busy_ab", 1'b1, busy);
        sar_host_model_i.strobe(1'b0);
        sar_host_model_i.read_bits(16, got);
        chk_word("kept", {prev, 4'h0}, got);
        chk_bit("ovr", 1'b0, ovr);
        wait_hi(1'b1, "acq_ab");
        $display("done abort");
    endtask
    initial begin
        clk = 1'b0;
        miscompares = 0;
        n_tests = 0;
        ain_code = 12'h000;
        t_reset();
        t_convert(12'hA5C);
        t_convert(12'hFFF);
        t_convert(12'h000);
        t_convert(12'h801);
        t_abort(12'h801);
        final_report();
    end
endmodule // test_sar_adc_serial_readout
`default_nettype wire
